// >>> sdt_pkg.sv
/*
 * Shared constants, types and decode functions for the slave drive
 * timing block: configuration offsets, field positions, reset values,
 * clock-count encodings and the channel timer states.
 * Assumes a single 50 MHz configuration/strobe clock.
 */
// Behaviour
// - secondary slave recovery from bits 5:4
// - primary slave sample point from bits 3:2
// - primary slave recovery from bits 1:0
// - vendor identity fixed, read-only, offset zero
// - writes to vendor identity are ignored
// - secondary slave sample point from bits 7:6
// - slave timing register at 44h, reset 00h
// - slave fields apply only when enable set
`default_nettype none

package sdt_pkg;

    typedef logic [1:0] sdt_code_t;
    typedef logic [2:0] sdt_count_t;

    typedef enum logic [1:0] {
        SDT_IDLE    = 2'b00,
        SDT_SAMPLE  = 2'b01,
        SDT_WAIT    = 2'b11,
        SDT_RECOVER = 2'b10
    } sdt_state_t;

    localparam logic [2:0] CFG_FUNC_IDE     = 3'h1;
    localparam logic [2:0] CFG_FUNC_USB     = 3'h2;
    localparam logic [7:0] OFF_VID_LO       = 8'h00;
    localparam logic [7:0] OFF_VID_HI       = 8'h01;
    localparam logic [7:0] OFF_SLAVE_TIMING = 8'h44;
    localparam logic [7:0] SLAVE_TIMING_RST = 8'h00;
    localparam logic [7:0] RDATA_RST        = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

    localparam int PRI_RTC_LSB = 0;
    localparam int PRI_ISP_LSB = 2;
    localparam int SEC_RTC_LSB = 4;
    localparam int SEC_ISP_LSB = 6;

    // code 00 is the slowest setting; each step saves one clock
    localparam sdt_count_t ISP_BASE = 3'h5;
    localparam sdt_count_t RTC_BASE = 3'h4;
    localparam sdt_count_t CNT_ONE  = 3'h1;
    localparam sdt_count_t CNT_MAX  = 3'h7;

    // arbitrary neutral value, not any real maker's code
    localparam logic [15:0] VENDOR_ID_DEFAULT = 16'h5D0C;

    function automatic sdt_code_t field_of(input logic [7:0] r,
                                           input int lsb);
        field_of = r[lsb +: 2];
    endfunction

    function automatic sdt_count_t isp_clocks(input sdt_code_t c);
        isp_clocks = ISP_BASE - {1'b0, c};
    endfunction

    function automatic sdt_count_t rtc_clocks(input sdt_code_t c);
        rtc_clocks = RTC_BASE - {1'b0, c};
    endfunction

endpackage

`default_nettype wire

// >>> sdt_chan_if.sv
/*
 * Per-channel link between the register side and one channel timer:
 * selected clock counts, cycle events and timer status.
 * Assumes all signals live on the single block clock.
 */
`default_nettype none

interface sdt_chan_if;
    import sdt_pkg::*;

    sdt_count_t isp_clocks;
    sdt_count_t rtc_clocks;
    logic       start;
    logic       last;
    logic       sample_open;
    logic       allow;

    modport ctrl (
        output isp_clocks,
        output rtc_clocks,
        output start,
        output last,
        input  sample_open,
        input  allow
    );

    modport timer (
        input  isp_clocks,
        input  rtc_clocks,
        input  start,
        input  last,
        output sample_open,
        output allow
    );
endinterface

`default_nettype wire

// >>> sdt_channel_timer.sv
/*
 * One channel's strobe timer: counts strobe-to-first-sample and
 * last-sample-to-next-strobe intervals in clocks.
 * Assumes start and last come from same-clock strobe logic.
 */
`default_nettype none

module sdt_channel_timer (
    input wire logic   clk_in,
    input wire logic   rst_in,
    sdt_chan_if.timer  chan
);
    import sdt_pkg::*;

    sdt_state_t state_q;
    sdt_state_t state_d;
    sdt_count_t cnt_q;
    sdt_count_t cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SDT_IDLE: begin
                if (chan.start) begin
                    state_d = SDT_SAMPLE;
                    cnt_d   = chan.isp_clocks;
                end
            end
            SDT_SAMPLE: begin
                if (cnt_q <= CNT_ONE) begin
                    state_d = SDT_WAIT;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            SDT_WAIT: begin
                if (chan.last) begin
                    state_d = SDT_RECOVER;
                    cnt_d   = chan.rtc_clocks;
                end
            end
            SDT_RECOVER: begin
                if (cnt_q <= CNT_ONE) begin
                    state_d = SDT_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            default: begin
                state_d = SDT_IDLE;
                cnt_d   = CNT_ONE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SDT_IDLE;
            cnt_q   <= CNT_ONE;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // start is ignored outside idle, so recovery cannot be cut short
    assign chan.sample_open = (state_q == SDT_WAIT);
    assign chan.allow       = (state_q == SDT_IDLE);

    // helper: edges since the load edge, and the count that was loaded
    sdt_count_t elapsed_q;
    sdt_count_t loaded_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            elapsed_q <= CNT_ONE;
            loaded_q  <= CNT_ONE;
        end else if ((state_q == SDT_IDLE && chan.start) ||
                     (state_q == SDT_WAIT && chan.last)) begin
            elapsed_q <= 3'h0;
            loaded_q  <= (state_q == SDT_IDLE) ? chan.isp_clocks
                                                : chan.rtc_clocks;
        end else if (elapsed_q != CNT_MAX) begin
            elapsed_q <= elapsed_q + CNT_ONE;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_window_delay;
        $rose(chan.sample_open) |-> elapsed_q == loaded_q;
    endproperty
    a_window_delay: assert property (p_window_delay)
        else $error("sample window opened at wrong clock");

    property p_recovery_delay;
        $rose(chan.allow) |-> elapsed_q == loaded_q;
    endproperty
    a_recovery_delay: assert property (p_recovery_delay)
        else $error("recovery ended at wrong clock");

    property p_start_blocked;
        $fell(chan.allow) |-> $past(chan.start);
    endproperty
    a_start_blocked: assert property (p_start_blocked)
        else $error("timer left idle without a start");

    c_window:   cover property (chan.allow && chan.start ##[1:5]
                                $rose(chan.sample_open));
    c_recovery: cover property (chan.sample_open && chan.last ##[1:4]
                                $rose(chan.allow));
endmodule

`default_nettype wire

// >>> sdt_slave_timing.sv
/*
 * Slave drive timing register bank: slave timing register in the IDE
 * function, read-only vendor identity in the USB function, and the
 * per-channel selection of sample-point and recovery counts that feed
 * two channel timers.
 * Assumes byte-wide configuration accesses on the same clock, one
 * access per cycle, with read data returned on the following edge.
 * Master timing codes and the enable bit come from the master timing
 * register outside this block.
 */
`default_nettype none

module sdt_slave_timing #(
    parameter logic [15:0] VENDOR_ID = sdt_pkg::VENDOR_ID_DEFAULT
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              cfg_rd_in,
    input  wire logic              cfg_wr_in,
    input  wire logic [2:0]        cfg_func_in,
    input  wire logic [7:0]        cfg_addr_in,
    input  wire logic [7:0]        cfg_wdata_in,
    output logic      [7:0]        cfg_rdata_out,
    input  wire logic              slave_timing_enable_in,
    input  wire sdt_pkg::sdt_code_t pri_master_isp_code_in,
    input  wire sdt_pkg::sdt_code_t pri_master_rtc_code_in,
    input  wire sdt_pkg::sdt_code_t sec_master_isp_code_in,
    input  wire sdt_pkg::sdt_code_t sec_master_rtc_code_in,
    input  wire logic              pri_drive_sel_in,
    input  wire logic              sec_drive_sel_in,
    input  wire logic              pri_cycle_start_in,
    input  wire logic              pri_last_sample_in,
    input  wire logic              sec_cycle_start_in,
    input  wire logic              sec_last_sample_in,
    output logic                   pri_sample_open_out,
    output logic                   pri_strobe_allow_out,
    output logic                   sec_sample_open_out,
    output logic                   sec_strobe_allow_out
);
    import sdt_pkg::*;

    logic [7:0] slave_drive_timing_q;
    logic [7:0] slave_drive_timing_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       ide_hit;
    logic       usb_hit;

    assign ide_hit = (cfg_func_in == CFG_FUNC_IDE);
    assign usb_hit = (cfg_func_in == CFG_FUNC_USB);

    always_comb begin
        slave_drive_timing_d = slave_drive_timing_q;
        // vendor identity has no storage, so writes there fall away
        if (cfg_wr_in && ide_hit && cfg_addr_in == OFF_SLAVE_TIMING) begin
            slave_drive_timing_d = cfg_wdata_in;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (cfg_rd_in) begin
            // unmapped offsets read as zero; no error is signalled
            rdata_d = RDATA_UNMAPPED;
            if (ide_hit && cfg_addr_in == OFF_SLAVE_TIMING) begin
                rdata_d = slave_drive_timing_q;
            end else if (usb_hit && cfg_addr_in == OFF_VID_LO) begin
                rdata_d = VENDOR_ID[7:0];
            end else if (usb_hit && cfg_addr_in == OFF_VID_HI) begin
                rdata_d = VENDOR_ID[15:8];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slave_drive_timing_q <= SLAVE_TIMING_RST;
            rdata_q              <= RDATA_RST;
        end else begin
            slave_drive_timing_q <= slave_drive_timing_d;
            rdata_q              <= rdata_d;
        end
    end

    assign cfg_rdata_out = rdata_q;

    sdt_chan_if pri_chan ();
    sdt_chan_if sec_chan ();

    logic pri_use_slave;
    logic sec_use_slave;

    // codes are taken live; the timer latches them when it loads
    assign pri_use_slave = slave_timing_enable_in && pri_drive_sel_in;
    assign sec_use_slave = slave_timing_enable_in && sec_drive_sel_in;

    always_comb begin
        pri_chan.isp_clocks = isp_clocks(pri_master_isp_code_in);
        pri_chan.rtc_clocks = rtc_clocks(pri_master_rtc_code_in);
        sec_chan.isp_clocks = isp_clocks(sec_master_isp_code_in);
        sec_chan.rtc_clocks = rtc_clocks(sec_master_rtc_code_in);
        if (pri_use_slave) begin
            pri_chan.isp_clocks = isp_clocks(
                field_of(slave_drive_timing_q, PRI_ISP_LSB));
            pri_chan.rtc_clocks = rtc_clocks(
                field_of(slave_drive_timing_q, PRI_RTC_LSB));
        end
        if (sec_use_slave) begin
            sec_chan.isp_clocks = isp_clocks(
                field_of(slave_drive_timing_q, SEC_ISP_LSB));
            sec_chan.rtc_clocks = rtc_clocks(
                field_of(slave_drive_timing_q, SEC_RTC_LSB));
        end
    end

    assign pri_chan.start = pri_cycle_start_in;
    assign pri_chan.last  = pri_last_sample_in;
    assign sec_chan.start = sec_cycle_start_in;
    assign sec_chan.last  = sec_last_sample_in;

    sdt_channel_timer u_pri_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .chan   (pri_chan.timer)
    );

    sdt_channel_timer u_sec_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .chan   (sec_chan.timer)
    );

    assign pri_sample_open_out  = pri_chan.sample_open;
    assign pri_strobe_allow_out = pri_chan.allow;
    assign sec_sample_open_out  = sec_chan.sample_open;
    assign sec_strobe_allow_out = sec_chan.allow;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_sec_recovery;
        sec_use_slave |->
            sec_chan.rtc_clocks == 3'h4 - {1'b0, slave_drive_timing_q[5:4]};
    endproperty
    a_sec_recovery: assert property (p_sec_recovery)
        else $error("secondary slave recovery count wrong");

    property p_pri_sample;
        pri_use_slave |->
            pri_chan.isp_clocks == 3'h5 - {1'b0, slave_drive_timing_q[3:2]};
    endproperty
    a_pri_sample: assert property (p_pri_sample)
        else $error("primary slave sample count wrong");

    property p_pri_recovery;
        pri_use_slave |->
            pri_chan.rtc_clocks == 3'h4 - {1'b0, slave_drive_timing_q[1:0]};
    endproperty
    a_pri_recovery: assert property (p_pri_recovery)
        else $error("primary slave recovery count wrong");

    // both bytes must come from reads on consecutive clocks
    property p_vid_read;
        cfg_rd_in && usb_hit && cfg_addr_in == 8'h00 ##1
            cfg_rd_in && usb_hit && cfg_addr_in == 8'h01 |=>
            {cfg_rdata_out, $past(cfg_rdata_out)} == VENDOR_ID;
    endproperty
    a_vid_read: assert property (p_vid_read)
        else $error("vendor identity read wrong");

    property p_vid_write;
        cfg_wr_in && !(ide_hit && cfg_addr_in == 8'h44) |=>
            $stable(slave_drive_timing_q);
    endproperty
    a_vid_write: assert property (p_vid_write)
        else $error("write outside slave timing changed state");

    property p_sec_sample;
        sec_use_slave |->
            sec_chan.isp_clocks == 3'h5 - {1'b0, slave_drive_timing_q[7:6]};
    endproperty
    a_sec_sample: assert property (p_sec_sample)
        else $error("secondary slave sample count wrong");

    property p_timing_rw;
        cfg_wr_in && ide_hit && cfg_addr_in == 8'h44 ##1
            cfg_rd_in && ide_hit && cfg_addr_in == 8'h44 && !cfg_wr_in
            |=> cfg_rdata_out == $past(cfg_wdata_in, 2);
    endproperty
    a_timing_rw: assert property (p_timing_rw)
        else $error("slave timing readback mismatch");

    property p_master_path;
        !(slave_timing_enable_in && pri_drive_sel_in) |->
            pri_chan.isp_clocks == 3'h5 - {1'b0, pri_master_isp_code_in} &&
            pri_chan.rtc_clocks == 3'h4 - {1'b0, pri_master_rtc_code_in};
    endproperty
    a_master_path: assert property (p_master_path)
        else $error("primary slave fields used while not selected");

    property p_sec_master_path;
        !(slave_timing_enable_in && sec_drive_sel_in) |->
            sec_chan.isp_clocks == 3'h5 - {1'b0, sec_master_isp_code_in} &&
            sec_chan.rtc_clocks == 3'h4 - {1'b0, sec_master_rtc_code_in};
    endproperty
    a_sec_master_path: assert property (p_sec_master_path)
        else $error("secondary slave fields used while not selected");

    property p_rdata_hold;
        !cfg_rd_in |=> $stable(cfg_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    c_slave_write: cover property (cfg_wr_in && ide_hit &&
                                   cfg_addr_in == OFF_SLAVE_TIMING);
    c_vid_read:    cover property (cfg_rd_in && usb_hit &&
                                   cfg_addr_in == OFF_VID_HI);
    c_slave_cycle: cover property (pri_use_slave && pri_cycle_start_in &&
                                   pri_strobe_allow_out);
endmodule

`default_nettype wire

// >>> sdt_drive_model.sv
/*
 * Behavioural model of the strobe engine and slave drive on one channel:
 * starts a cycle on request, waits for the sample window, optionally
 * stalls, signals the last ready sample and waits for recovery.
 * Assumes inputs are settled at the falling clock edge.
 */
`default_nettype none

module sdt_drive_model (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [1:0] hold_in,
    input  wire logic       sample_open_in,
    input  wire logic       allow_in,
    output logic            start_out,
    output logic            last_out,
    output logic            busy_out,
    output logic [3:0]      isp_seen_out,
    output logic [3:0]      rtc_seen_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // counts are edges after the start or last edge, seen at falling edge
    initial begin
        start_out = 1'b0;
        last_out = 1'b0;
        busy_out = 1'b0;
        isp_seen_out = 4'h0;
        rtc_seen_out = 4'h0;
        forever begin
            @(negedge clk_in);
            if (go_in && allow_in) begin
                busy_out = 1'b1;
                start_out = 1'b1;
                @(negedge clk_in);
                start_out = 1'b0;
                isp_seen_out = 4'h0;
                while (!sample_open_in && isp_seen_out < 4'hF) begin
                    @(negedge clk_in);
                    isp_seen_out++;
                end
                // slow drive: window held open before the last sample
                repeat (hold_in) @(negedge clk_in);
                last_out = 1'b1;
                @(negedge clk_in);
                last_out = 1'b0;
                rtc_seen_out = 4'h0;
                while (!allow_in && rtc_seen_out < 4'hF) begin
                    @(negedge clk_in);
                    rtc_seen_out++;
                end
                busy_out = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb_sdt_slave_timing.sv
/*
 * Self-checking bench for the slave drive timing block: configuration
 * reads and writes, then timed cycles on both channels.
 * Assumes the drive model file and the design files are compiled first.
 */
`default_nettype none

module tb_sdt_slave_timing;
    import sdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // arbitrary identity value for the bench
    localparam logic [15:0] TB_VID = 16'hA35C;

    logic       clk_in, rst_in, cfg_rd_in, cfg_wr_in;
    logic [2:0] cfg_func_in;
    logic [7:0] cfg_addr_in, cfg_wdata_in, cfg_rdata_out;
    logic       slave_timing_enable_in, pri_drive_sel_in, sec_drive_sel_in;
    sdt_code_t  pri_master_isp_code_in, pri_master_rtc_code_in;
    sdt_code_t  sec_master_isp_code_in, sec_master_rtc_code_in;
    logic       pri_cycle_start_in, pri_last_sample_in;
    logic       sec_cycle_start_in, sec_last_sample_in;
    logic       pri_sample_open_out, pri_strobe_allow_out;
    logic       sec_sample_open_out, sec_strobe_allow_out;
    logic       go_pri, go_sec, busy_pri, busy_sec;
    logic [1:0] hold;
    logic [3:0] pi_seen, pr_seen, si_seen, sr_seen;
    int         errors, tests_run, cycles;

    always #10 clk_in = ~clk_in;

    sdt_slave_timing #(.VENDOR_ID(TB_VID)) i_sdt_slave_timing (
        .clk_in, .rst_in, .cfg_rd_in, .cfg_wr_in, .cfg_func_in,
        .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out,
        .slave_timing_enable_in, .pri_master_isp_code_in,
        .pri_master_rtc_code_in, .sec_master_isp_code_in,
        .sec_master_rtc_code_in, .pri_drive_sel_in, .sec_drive_sel_in,
        .pri_cycle_start_in, .pri_last_sample_in, .sec_cycle_start_in,
        .sec_last_sample_in, .pri_sample_open_out, .pri_strobe_allow_out,
        .sec_sample_open_out, .sec_strobe_allow_out
    );

    sdt_drive_model i_sdt_drive_model_pri (
        .clk_in(clk_in), .go_in(go_pri), .hold_in(hold),
        .sample_open_in(pri_sample_open_out),
        .allow_in(pri_strobe_allow_out), .start_out(pri_cycle_start_in),
        .last_out(pri_last_sample_in), .busy_out(busy_pri),
        .isp_seen_out(pi_seen), .rtc_seen_out(pr_seen)
    );

    sdt_drive_model i_sdt_drive_model_sec (
        .clk_in(clk_in), .go_in(go_sec), .hold_in(hold),
        .sample_open_in(sec_sample_open_out),
        .allow_in(sec_strobe_allow_out), .start_out(sec_cycle_start_in),
        .last_out(sec_last_sample_in), .busy_out(busy_sec),
        .isp_seen_out(si_seen), .rtc_seen_out(sr_seen)
    );

    task automatic report_and_stop();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("[FAIL] run length expected below 3000 seen 3000");
            report_and_stop();
        end
    end

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // called at a falling edge; strobes stay up so calls run back to back
    task automatic cfg_write(logic [2:0] f, logic [7:0] a, logic [7:0] d);
        cfg_func_in = f;
        cfg_addr_in = a;
        cfg_wdata_in = d;
        cfg_rd_in = 1'b0;
        cfg_wr_in = 1'b1;
        @(negedge clk_in);
    endtask

    task automatic cfg_read(logic [2:0] f, logic [7:0] a, logic [7:0] exp);
        cfg_func_in = f;
        cfg_addr_in = a;
        cfg_wr_in = 1'b0;
        cfg_rd_in = 1'b1;
        @(negedge clk_in);
        check8($sformatf("cfg f%0d a%h", f, a), exp, cfg_rdata_out);
    endtask

    // codes give 5-code sample clocks and 4-code recovery clocks
    task automatic run_chans(logic [1:0] h, sdt_code_t pi, sdt_code_t pr,
                             sdt_code_t si, sdt_code_t sr);
        int n;
        n = 0;
        cfg_rd_in = 1'b0;
        cfg_wr_in = 1'b0;
        @(negedge clk_in);
        hold <= h;
        go_pri <= 1'b1;
        go_sec <= 1'b1;
        @(negedge clk_in);
        go_pri <= 1'b0;
        go_sec <= 1'b0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((busy_pri || busy_sec) && n < 100);
        if (n >= 100) begin
            errors++;
            $display("[FAIL] channel run expected idle seen busy");
        end
        check8("pri sample", 8'h05 - pi, {4'h0, pi_seen});
        check8("pri recov", 8'h04 - pr, {4'h0, pr_seen});
        check8("sec sample", 8'h05 - si, {4'h0, si_seen});
        check8("sec recov", 8'h04 - sr, {4'h0, sr_seen});
        @(negedge clk_in);
    endtask

    initial begin
        sdt_code_t c;
        clk_in = 1'b0;
        rst_in = 1'b1;
        {cfg_rd_in, cfg_wr_in, go_pri, go_sec} = 4'h0;
        cfg_func_in = 3'h0;
        cfg_addr_in = 8'h00;
        cfg_wdata_in = 8'h00;
        hold = 2'h0;
        slave_timing_enable_in = 1'b0;
        pri_drive_sel_in = 1'b0;
        sec_drive_sel_in = 1'b0;
        pri_master_isp_code_in = 2'h0;
        pri_master_rtc_code_in = 2'h3;
        sec_master_isp_code_in = 2'h2;
        sec_master_rtc_code_in = 2'h1;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        cfg_read(3'h1, 8'h44, 8'h00);
        cfg_read(3'h2, 8'h00, TB_VID[7:0]);
        cfg_read(3'h2, 8'h01, TB_VID[15:8]);
        cfg_write(3'h2, 8'h00, 8'hFF);
        cfg_write(3'h2, 8'h01, 8'h00);
        cfg_read(3'h2, 8'h00, TB_VID[7:0]);
        cfg_read(3'h2, 8'h01, TB_VID[15:8]);
        cfg_write(3'h2, 8'h44, 8'hA5);
        cfg_read(3'h1, 8'h44, 8'h00);
        cfg_read(3'h1, 8'h45, 8'h00);
        cfg_write(3'h1, 8'h44, 8'hA5);
        cfg_read(3'h1, 8'h44, 8'hA5);
        cfg_write(3'h1, 8'h44, 8'h5A);
        cfg_read(3'h1, 8'h44, 8'h5A);
        slave_timing_enable_in = 1'b1;
        pri_drive_sel_in = 1'b1;
        sec_drive_sel_in = 1'b1;
        // every field takes a different code so swapped fields show
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            cfg_write(3'h1, 8'h44, {c, c + 2'h1, c + 2'h2, c + 2'h3});
            run_chans(c, c + 2'h2, c + 2'h3, c, c + 2'h1);
        end
        slave_timing_enable_in = 1'b0;
        run_chans(2'h0, 2'h0, 2'h3, 2'h2, 2'h1);
        slave_timing_enable_in = 1'b1;
        sec_drive_sel_in = 1'b0;
        run_chans(2'h1, 2'h1, 2'h2, 2'h2, 2'h1);
        // mid-run reset must clear the timing register again
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        cfg_read(3'h1, 8'h44, 8'h00);
        report_and_stop();
    end
endmodule

`default_nettype wire
